// [uwk_uart.sv]
// UART channel in 8-bit and 9-bit modes with parity and multiprocessor wake-up.
`timescale 1ns/10ps
// What this block does
// [R1] Mode field value 2'b10 runs the channel as an 8-bit-data UART.
// [R2] In 8-bit mode a parity bit is sent and checked only while parity is enabled, even or odd.
// [R3] Mode field value 2'b11 runs the channel as a 9-bit-data UART.
// [R4] Software keeps parity disabled in 9-bit mode, since parity is not allowed there.
// [R5] In 9-bit mode the transmit ninth bit is sent as the ninth data bit.
// [R6] In 9-bit mode the received ninth bit is stored in the receive ninth bit.
// [R7] Software writes the transmit ninth bit before the data, and reads the receive one first.
// [R8] In 9-bit mode the number of stop bits sent follows the stop length select.
// [R9] In 9-bit mode the wake-up enable puts the receiver into wake-up mode.
// [R10] In wake-up mode only frames with ninth bit 1 raise the receive interrupt.
// [R11] A master selects a slave with one frame holding an 8-bit code and ninth bit 1.
// [R12] A slave whose code matched clears its wake-up enable to accept data frames.
// [R13] After selection the master sends data frames with ninth bit 0.
// [R14] Only the selected slave may reply to the master.
// [R15] Slave transmit pins are open-drain so several slaves share the return line.
// [R16] A frame is a low start bit, data LSB first, optional extra bit, then high stop bits.
module uwk_uart #(
   parameter int BIT_CYCLES = uwk_pkg::BIT_CYCLES,
   parameter int HALF_CYCLES = uwk_pkg::HALF_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [1:0] mode_select_field,
   input wire logic parity_enable,
   input wire logic even_parity_select,
   input wire logic stop_length_select,
   input wire logic wakeup_enable,
   input wire logic open_drain_select,
   input wire logic transmit_ninth_bit,
   input wire logic [7:0] tx_data,
   input wire logic tx_write,
   input wire logic rx_enable,
   input wire logic rxd,
   output logic txd_out,
   output logic txd_oe,
   output logic tx_busy,
   output logic tx_done,
   output logic [7:0] rx_data,
   output logic receive_ninth_bit,
   output logic receive_interrupt,
   output logic parity_error,
   output logic framing_error
);
   localparam logic [uwk_pkg::CNT_W-1:0] BIT_LAST = uwk_pkg::CNT_W'(BIT_CYCLES - 1);
   localparam logic [uwk_pkg::CNT_W-1:0] HALF_LAST = uwk_pkg::CNT_W'(HALF_CYCLES - 1);
   localparam logic [2:0] DATA_LAST = 3'(uwk_pkg::DATA_BITS - 1);

   function automatic logic frame_mode_ok(input logic [1:0] mode);
      frame_mode_ok = (mode == uwk_pkg::MODE_UART8) || (mode == uwk_pkg::MODE_UART9);
   endfunction

   function automatic logic parity_bit(input logic [7:0] data, input logic even);
      parity_bit = even ? ^data : ~^data;
   endfunction

   function automatic logic has_extra(input logic [1:0] mode, input logic par_on);
      has_extra = (mode == uwk_pkg::MODE_UART9) || (mode == uwk_pkg::MODE_UART8 && par_on);
   endfunction

   // Transmitter: one frame at a time, with controls captured at acceptance.
   uwk_pkg::uwk_phase_e tx_state;
   logic [uwk_pkg::CNT_W-1:0] tx_cnt;
   logic [2:0] tx_bit;
   logic [7:0] tx_shift;
   logic tx_line;
   logic tx_extra;
   logic tx_has_extra;
   logic [1:0] tx_nstop;
   logic tx_accept;
   logic tx_tick;
   logic tx_last_stop;

   assign tx_accept = tx_write && tx_state == uwk_pkg::PH_IDLE && frame_mode_ok(mode_select_field);
   assign tx_tick = tx_cnt == BIT_LAST;
   assign tx_last_stop = tx_state == uwk_pkg::PH_STOP && tx_tick && (2'(tx_bit) + 2'h1 == tx_nstop);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         tx_cnt <= '0;
      end else if (ce) begin
         if (tx_state == uwk_pkg::PH_IDLE || tx_tick) begin
            tx_cnt <= '0;
         end else begin
            tx_cnt <= tx_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         tx_state <= uwk_pkg::PH_IDLE;
         tx_line <= uwk_pkg::LINE_IDLE;
         tx_bit <= '0;
         tx_shift <= '0;
         tx_extra <= 1'b0;
         tx_has_extra <= 1'b0;
         tx_nstop <= uwk_pkg::STOP_ONE;
      end else if (ce) begin
         unique case (tx_state)
            uwk_pkg::PH_IDLE: begin
               // The ninth bit and parity are captured with the data, so software must set
               // the ninth bit before it strobes the write.
               if (tx_accept) begin // [R1] [R3]
                  tx_state <= uwk_pkg::PH_START;
                  tx_line <= uwk_pkg::LINE_START; // [R16]
                  tx_shift <= tx_data;
                  tx_has_extra <= has_extra(mode_select_field, parity_enable); // [R2]
                  if (mode_select_field == uwk_pkg::MODE_UART9) begin
                     tx_extra <= transmit_ninth_bit; // [R5]
                  end else begin
                     tx_extra <= parity_bit(tx_data, even_parity_select); // [R2]
                  end
                  if (mode_select_field == uwk_pkg::MODE_UART9 && stop_length_select) begin
                     tx_nstop <= uwk_pkg::STOP_TWO; // [R8]
                  end else begin
                     tx_nstop <= uwk_pkg::STOP_ONE;
                  end
               end
            end
            uwk_pkg::PH_START: begin
               if (tx_tick) begin
                  tx_state <= uwk_pkg::PH_DATA;
                  tx_line <= tx_shift[0]; // [R16]
                  tx_bit <= '0;
               end
            end
            uwk_pkg::PH_DATA: begin
               if (tx_tick) begin
                  tx_shift <= {1'b0, tx_shift[7:1]};
                  if (tx_bit == DATA_LAST) begin
                     tx_bit <= '0;
                     tx_state <= tx_has_extra ? uwk_pkg::PH_EXTRA : uwk_pkg::PH_STOP;
                     tx_line <= tx_has_extra ? tx_extra : uwk_pkg::LINE_IDLE;
                  end else begin
                     tx_bit <= tx_bit + 3'h1;
                     tx_line <= tx_shift[1];
                  end
               end
            end
            uwk_pkg::PH_EXTRA: begin
               if (tx_tick) begin
                  tx_state <= uwk_pkg::PH_STOP;
                  tx_line <= uwk_pkg::LINE_IDLE; // [R16]
               end
            end
            uwk_pkg::PH_STOP: begin
               if (tx_last_stop) begin // [R8]
                  tx_state <= uwk_pkg::PH_IDLE;
                  tx_bit <= '0;
               end else if (tx_tick) begin
                  tx_bit <= tx_bit + 3'h1;
               end
            end
            default: begin
               tx_state <= uwk_pkg::PH_IDLE;
               tx_line <= uwk_pkg::LINE_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         tx_busy <= 1'b0;
         tx_done <= 1'b0;
      end else if (ce) begin
         tx_done <= tx_last_stop;
         if (tx_accept) begin
            tx_busy <= 1'b1;
         end else if (tx_last_stop) begin
            tx_busy <= 1'b0;
         end
      end
   end

   // Open-drain drives only lows, so a shared return line never sees two drivers fighting.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         txd_out <= uwk_pkg::LINE_IDLE;
         txd_oe <= 1'b0;
      end else if (ce) begin
         txd_out <= open_drain_select ? 1'b0 : tx_line; // [R15]
         txd_oe <= open_drain_select ? !tx_line : 1'b1;
      end
   end

   // Receiver: samples each bit in its middle after a confirmed start bit.
   uwk_pkg::uwk_phase_e rx_state;
   logic rx_s;
   logic [uwk_pkg::CNT_W-1:0] rx_cnt;
   logic [2:0] rx_bit;
   logic [7:0] rx_shift;
   logic rx_extra;
   logic rx_has_extra;
   logic rx_mode9;
   logic rx_check_parity;
   logic rx_even;
   logic rx_tick;
   logic rx_deliver;
   logic rx_ignore;

   uwk_pin_sync #(.RESET_LEVEL(uwk_pkg::LINE_IDLE)) rxd_sync (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .pin(rxd),
      .level(rx_s)
   );

   assign rx_tick = rx_cnt == ((rx_state == uwk_pkg::PH_START) ? HALF_LAST : BIT_LAST);
   assign rx_deliver = rx_state == uwk_pkg::PH_STOP && rx_tick;
   assign rx_ignore = rx_mode9 && wakeup_enable && !rx_extra; // [R9] [R10]

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rx_cnt <= '0;
      end else if (ce) begin
         if (rx_state == uwk_pkg::PH_IDLE || rx_tick) begin
            rx_cnt <= '0;
         end else begin
            rx_cnt <= rx_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rx_state <= uwk_pkg::PH_IDLE;
         rx_bit <= '0;
         rx_shift <= '0;
         rx_extra <= 1'b0;
         rx_has_extra <= 1'b0;
         rx_mode9 <= 1'b0;
         rx_check_parity <= 1'b0;
         rx_even <= 1'b0;
      end else if (ce) begin
         unique case (rx_state)
            uwk_pkg::PH_IDLE: begin
               if (rx_enable && frame_mode_ok(mode_select_field) && !rx_s) begin // [R1] [R3]
                  rx_state <= uwk_pkg::PH_START;
                  rx_has_extra <= has_extra(mode_select_field, parity_enable);
                  rx_mode9 <= mode_select_field == uwk_pkg::MODE_UART9;
                  rx_check_parity <= mode_select_field == uwk_pkg::MODE_UART8 && parity_enable;
                  rx_even <= even_parity_select;
                  rx_extra <= 1'b0;
               end
            end
            uwk_pkg::PH_START: begin
               // A start bit that is high again at mid-bit was a glitch.
               if (rx_tick) begin
                  rx_state <= rx_s ? uwk_pkg::PH_IDLE : uwk_pkg::PH_DATA; // [R16]
                  rx_bit <= '0;
               end
            end
            uwk_pkg::PH_DATA: begin
               if (rx_tick) begin
                  rx_shift <= {rx_s, rx_shift[7:1]}; // [R16]
                  rx_bit <= rx_bit + 3'h1;
                  if (rx_bit == DATA_LAST) begin
                     rx_state <= rx_has_extra ? uwk_pkg::PH_EXTRA : uwk_pkg::PH_STOP;
                  end
               end
            end
            uwk_pkg::PH_EXTRA: begin
               if (rx_tick) begin
                  rx_extra <= rx_s;
                  rx_state <= uwk_pkg::PH_STOP;
               end
            end
            uwk_pkg::PH_STOP: begin
               if (rx_tick) begin
                  rx_state <= uwk_pkg::PH_IDLE;
               end
            end
            default: begin
               rx_state <= uwk_pkg::PH_IDLE;
            end
         endcase
      end
   end

   // Ignored frames leave data and flags untouched, so an address-hunting slave keeps its last data.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rx_data <= '0;
         receive_ninth_bit <= 1'b0;
         receive_interrupt <= 1'b0;
         parity_error <= 1'b0;
         framing_error <= 1'b0;
      end else if (ce) begin
         receive_interrupt <= rx_deliver && !rx_ignore; // [R10]
         if (rx_deliver && !rx_ignore) begin
            rx_data <= rx_shift;
            if (rx_mode9) begin
               receive_ninth_bit <= rx_extra; // [R6]
            end
            parity_error <= rx_check_parity && (rx_extra != parity_bit(rx_shift, rx_even)); // [R2]
            framing_error <= !rx_s; // [R16]
         end
      end
   end

   // Checks on the behaviour that the rules ask of this side.
   sequence tx_accept_s;
      ce && tx_write && tx_state == uwk_pkg::PH_IDLE && frame_mode_ok(mode_select_field);
   endsequence

   sequence rx_frame_end_s;
      ce && rx_deliver;
   endsequence

   mode_gate_a: assert property (@(posedge clk) disable iff (!resetn) // [R1] [R3]
      ce && tx_write && tx_state == uwk_pkg::PH_IDLE && !frame_mode_ok(mode_select_field)
      |=> !tx_busy && tx_state == uwk_pkg::PH_IDLE)
      else $error("transmit started in an unsupported mode");

   start_bit_a: assert property (@(posedge clk) disable iff (!resetn) // [R16]
      tx_accept_s |=> (tx_busy && tx_state == uwk_pkg::PH_START
      && tx_line == uwk_pkg::LINE_START) ##0 (!ce or (ce ##1 txd_out == 1'b0)))
      else $error("frame did not open with a low start bit");

   parity_setup_a: assert property (@(posedge clk) disable iff (!resetn) // [R2]
      tx_accept_s and (mode_select_field == uwk_pkg::MODE_UART8)
      |=> tx_has_extra == $past(parity_enable)
      && tx_extra == parity_bit($past(tx_data), $past(even_parity_select)))
      else $error("parity bit wrong or present while disabled");

   ninth_tx_a: assert property (@(posedge clk) disable iff (!resetn) // [R5]
      tx_accept_s and (mode_select_field == uwk_pkg::MODE_UART9)
      |=> tx_has_extra && tx_extra == $past(transmit_ninth_bit))
      else $error("ninth bit not taken from the transmit ninth bit");

   extra_line_a: assert property (@(posedge clk) disable iff (!resetn) // [R16]
      tx_state == uwk_pkg::PH_EXTRA |-> tx_line == tx_extra)
      else $error("line does not carry the extra bit");

   stop_len_a: assert property (@(posedge clk) disable iff (!resetn) // [R8]
      tx_accept_s |=> tx_nstop == (($past(mode_select_field) == uwk_pkg::MODE_UART9
      && $past(stop_length_select)) ? uwk_pkg::STOP_TWO : uwk_pkg::STOP_ONE))
      else $error("stop bit count does not follow stop length select");

   stop_high_a: assert property (@(posedge clk) disable iff (!resetn) // [R16]
      tx_state == uwk_pkg::PH_STOP |-> tx_line == uwk_pkg::LINE_IDLE)
      else $error("stop bit not high");

   wake_filter_a: assert property (@(posedge clk) disable iff (!resetn) // [R9] [R10]
      rx_frame_end_s and (rx_mode9 && wakeup_enable && !rx_extra) |=> !receive_interrupt)
      else $error("interrupt raised for a data frame in wake-up mode");

   ninth_rx_a: assert property (@(posedge clk) disable iff (!resetn) // [R6]
      rx_frame_end_s and (rx_mode9 && !rx_ignore)
      |=> receive_interrupt && receive_ninth_bit == $past(rx_extra))
      else $error("received ninth bit not stored");
endmodule // uwk_uart

// [uwk_pkg.sv]
// Shared constants and types for the 8/9-bit UART with wake-up filtering.
package uwk_pkg;
   localparam logic [1:0] MODE_UART8 = 2'h2;
   localparam logic [1:0] MODE_UART9 = 2'h3;
   localparam int CLK_HZ = 10000000;
   localparam int BAUD_BPS = 9600;
   localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS;
   localparam int HALF_CYCLES = BIT_CYCLES / 2;
   localparam int DATA_BITS = 8;
   localparam int CNT_W = 16;
   localparam logic [1:0] STOP_ONE = 2'h1;
   localparam logic [1:0] STOP_TWO = 2'h2;
   localparam logic LINE_IDLE = 1'b1;
   localparam logic LINE_START = 1'b0;
   typedef enum logic [2:0] {
      PH_IDLE  = 3'h0,
      PH_START = 3'h1,
      PH_DATA  = 3'h2,
      PH_EXTRA = 3'h3,
      PH_STOP  = 3'h4
   } uwk_phase_e;
endpackage

// [uwk_pin_sync.sv]
// Three-stage pin synchroniser whose output moves only when stages two and three agree.
`timescale 1ns/10ps
module uwk_pin_sync #(
   parameter logic RESET_LEVEL = 1'b1
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic pin,
   output logic level
);
   logic meta;
   logic stage2;
   logic stage3;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta <= RESET_LEVEL;
         stage2 <= RESET_LEVEL;
         stage3 <= RESET_LEVEL;
         level <= RESET_LEVEL;
      end else if (ce) begin
         meta <= pin;
         stage2 <= meta;
         stage3 <= stage2;
         if (stage2 == stage3) begin
            level <= stage2;
         end
      end
   end

   sync_agree_a: assert property (@(posedge clk) disable iff (!resetn)
      ce && stage2 != stage3 |=> $stable(level))
      else $error("synchronised level moved while stages disagreed");
endmodule // uwk_pin_sync

// [uwk_far_end.sv]
// Far-end serial controller that drives the receive pin and decodes the shared line.
`timescale 1ns/10ps
module uwk_far_end #(
   parameter int BIT = 16
) (
   input wire logic clk,
   input wire logic line,
   output logic rxd
);
   initial rxd = 1'b1;

   // Bits are given start first, so a frame leaves least significant bit first.
   task automatic send(input logic [11:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         rxd = bits[i];
         repeat (BIT - 1) @(negedge clk);
      end
      @(negedge clk);
      // The pin idles at the pulled-up level between frames.
      rxd = 1'b1;
   endtask

   // Samples each bit in its middle after the start edge; gives up after a bounded wait.
   task automatic grab(output logic [11:0] bits, input int n);
      int t;
      bits = '0;
      for (t = 0; t < 200 && line !== 1'b0; t++) @(negedge clk);
      if (line === 1'b0) begin
         repeat (BIT / 2) @(negedge clk);
         for (int i = 0; i < n; i++) begin
            bits[i] = line;
            if (i < n - 1) repeat (BIT) @(negedge clk);
         end
      end
   endtask
endmodule // uwk_far_end

// [uwk_uart_test.sv]
// Self-checking testbench for the 8/9-bit UART with wake-up filtering.
`timescale 1ns/10ps
module uwk_uart_test;
   localparam int BIT = 16;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic [1:0] mode = 2'h0;
   logic par_en = 1'b0;
   logic even = 1'b0;
   logic stop2 = 1'b0;
   logic wake = 1'b0;
   logic od = 1'b0;
   logic ninth = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic tx_write = 1'b0;
   logic rx_enable = 1'b1;
   logic rxd;
   logic txd_out, txd_oe, tx_busy, tx_done, receive_ninth_bit, receive_interrupt;
   logic parity_error, framing_error;
   logic [7:0] rx_data;
   wire line;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;

   // The return line has a pull-up, so an undriven pin reads high.
   assign line = (txd_oe === 1'b1) ? txd_out : 1'b1;
   always #50 clk = ~clk;

   uwk_uart #(.BIT_CYCLES(BIT), .HALF_CYCLES(BIT / 2)) i_dut (.clk(clk), .resetn(resetn),
      .ce(ce), .mode_select_field(mode), .parity_enable(par_en), .even_parity_select(even),
      .stop_length_select(stop2), .wakeup_enable(wake), .open_drain_select(od),
      .transmit_ninth_bit(ninth), .tx_data(tx_data), .tx_write(tx_write),
      .rx_enable(rx_enable), .rxd(rxd), .txd_out(txd_out), .txd_oe(txd_oe),
      .tx_busy(tx_busy), .tx_done(tx_done), .rx_data(rx_data),
      .receive_ninth_bit(receive_ninth_bit), .receive_interrupt(receive_interrupt),
      .parity_error(parity_error), .framing_error(framing_error));

   uwk_far_end #(.BIT(BIT)) i_far (.clk(clk), .line(line), .rxd(rxd));

   task automatic tally_and_finish;
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         errors++;
         tally_and_finish;
      end
   end

   task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   function automatic int build(input logic [7:0] d, input bit extra, input logic xb,
                                input int stops, output logic [11:0] f);
      int k;
      f = '1;
      f[0] = 1'b0;
      f[8:1] = d;
      k = 9;
      if (extra) begin
         f[9] = xb;
         k = 10;
      end
      return k + stops;
   endfunction

   task automatic set(input logic [1:0] m, input logic p, input logic ev, input logic s2,
                      input logic w, input logic o);
      @(negedge clk);
      mode = m;
      par_en = p;
      even = ev;
      stop2 = s2;
      wake = w;
      od = o;
   endtask

   task automatic tx_check(input logic [7:0] d, input logic nb);
      logic [11:0] exp, got;
      int n, st, cnt;
      bit nine, low;
      logic xb;
      nine = (mode == uwk_pkg::MODE_UART9);
      st = (nine && stop2) ? 2 : 1;
      xb = nine ? nb : (even ? ^d : ~^d);
      n = build(d, nine || par_en, xb, st, exp);
      @(negedge clk);
      tx_data = d;
      ninth = nb;
      tx_write = 1'b1;
      @(negedge clk);
      tx_write = 1'b0;
      chk("tx_busy", 12'h1, 12'(tx_busy));
      // Only the first stop bit is sampled; the second one is watched while waiting.
      i_far.grab(got, n - st + 1);
      chk("tx_frame", exp & ((12'h1 << (n - st + 1)) - 12'h1), got);
      low = 1'b0;
      for (cnt = 0; cnt < 3 * BIT && tx_done !== 1'b1; cnt++) begin
         @(negedge clk);
         if (line !== 1'b1) low = 1'b1;
      end
      chk("stop_count", 12'(st - 1), 12'(cnt / BIT));
      chk("stop_level", 12'h0, 12'(low));
      chk("tx_done", 12'h1, 12'(tx_done));
      chk("tx_idle", 12'h0, 12'(tx_busy));
   endtask

   task automatic rx_check(input logic [7:0] d, input logic nb, input logic bad, input bit irq);
      logic [11:0] f;
      logic [7:0] old;
      int n;
      bit nine, got;
      nine = (mode == uwk_pkg::MODE_UART9);
      n = build(d, nine || par_en, nine ? nb : ((even ? ^d : ~^d) ^ bad), 1, f);
      old = rx_data;
      got = 1'b0;
      fork
         i_far.send(f, n);
         for (int t = 0; t < (n + 1) * BIT; t++) begin
            @(negedge clk);
            if (receive_interrupt === 1'b1) got = 1'b1;
         end
      join
      chk("rx_irq", 12'(irq), 12'(got));
      chk("rx_data", 12'(irq ? d : old), 12'(rx_data));
      if (irq && nine) chk("rx_ninth", 12'(nb), 12'(receive_ninth_bit));
      if (irq) chk("parity_error", 12'(bad), 12'(parity_error));
      if (irq) chk("framing_error", 12'h0, 12'(framing_error));
   endtask

   // A frame whose stop bit is low is still delivered, flagged as a framing error.
   task automatic frame_check(input logic [7:0] d);
      logic [11:0] f;
      int n;
      n = build(d, 1'b0, 1'b0, 1, f);
      f[n - 1] = 1'b0;
      i_far.send(f, n);
      // Let the receiver reject the false start that the still-low stop bit looks like.
      repeat (BIT) @(negedge clk);
      chk("framing_error", 12'h1, 12'(framing_error));
      chk("bad_stop_data", 12'(d), 12'(rx_data));
   endtask

   // An idle mode and a frozen clock enable must both swallow a write.
   task automatic hold_check;
      set(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      tx_write = 1'b1;
      @(negedge clk);
      tx_write = 1'b0;
      @(negedge clk);
      chk("idle_busy", 12'h0, 12'(tx_busy));
      chk("idle_line", 12'h1, 12'(txd_out));
      chk("idle_oe", 12'h1, 12'(txd_oe));
      set(uwk_pkg::MODE_UART8, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      ce = 1'b0;
      tx_write = 1'b1;
      @(negedge clk);
      tx_write = 1'b0;
      @(negedge clk);
      ce = 1'b1;
      @(negedge clk);
      chk("frozen_busy", 12'h0, 12'(tx_busy));
   endtask

   initial begin
      repeat (2) @(posedge clk);
      @(negedge clk);
      resetn = 1'b1;
      set(uwk_pkg::MODE_UART8, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      tx_check(8'ha5, 1'b0);
      rx_check(8'h3c, 1'b0, 1'b0, 1'b1);
      frame_check(8'h6d);
      rx_enable = 1'b0;
      rx_check(8'h55, 1'b0, 1'b0, 1'b0);
      rx_enable = 1'b1;
      for (int e = 0; e < 2; e++) begin
         set(uwk_pkg::MODE_UART8, 1'b1, 1'(e), 1'b0, 1'b0, 1'b0);
         tx_check(8'h96, 1'b0);
         rx_check(8'h71, 1'b0, 1'b0, 1'b1);
         rx_check(8'h0f, 1'b0, 1'b1, 1'b1);
      end
      // Parity stays off in 9-bit mode.
      set(uwk_pkg::MODE_UART9, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      tx_check(8'h5a, 1'b1);
      set(uwk_pkg::MODE_UART9, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      tx_check(8'hc3, 1'b0);
      chk("od_out", 12'h0, 12'(txd_out));
      chk("od_oe", 12'h0, 12'(txd_oe));
      rx_check(8'he1, 1'b1, 1'b0, 1'b1);
      set(uwk_pkg::MODE_UART9, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
      rx_check(8'h42, 1'b0, 1'b0, 1'b0);
      rx_check(8'h17, 1'b1, 1'b0, 1'b1);
      set(uwk_pkg::MODE_UART9, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      rx_check(8'h88, 1'b0, 1'b0, 1'b1);
      tx_check(8'h3e, 1'b0);
      hold_check;
      tally_and_finish;
   end
endmodule // uwk_uart_test
